//--- core/abs_position_reader.sv
// power-on absolute position reader with Avalon-MM register slave
// assumes: internal X/Y bus returns 24-bit words; one motor per instance
// Overview of operation
// - bit 22 picks register space, 0 Y, 1 X, parallel mode
// - bit 23 zero means unsigned, one means signed
// - whole word zero skips the read; software nonzeroes it
// - top bytes 08-30,48-70,88-B0,C8-F0 are parallel reads, 8-48 bits
// - expansion ports read from Y space at addresses from FFD0
// - timer capture uses width 24, X space, unsigned
// - built-in capture channels sit in X at C000, step 8
// - older expansion capture channels sit in X at C020, step 4
// - codes 31/B1 take upper 16 bits of the Y register
// - older A/D channels in pairs ending 6 and 7, pairs 8 apart
// - codes 32/B2 read the serial encoder board in Y space
// - first hex digit 3 unsigned, B signed for serial encoder
// - encoder board bases FFD0..FFF8 step 8, second encoder at plus 4
// - widths above 24 fetch high bits from next address
// - position becomes sensor value minus home offset
// - power-up mode bit 2 suppresses the automatic read; here the mode resets to 00, so the power-on read always runs
//
// Implementation choices: the Avalon-MM register port and the register addresses.
module abs_position_reader
	import abs_reader_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// internal X/Y sensor bus
	output logic mem_rd_o,
	output logic mem_xspace_o,
	output logic [15:0] mem_addr_o,
	input wire logic [23:0] mem_rdata_i,
	input wire logic mem_valid_i,
	// result
	output logic [47:0] position_o,
	output logic position_valid_o
);
	typedef struct packed {
		rd_state_e st;
		logic [23:0] sel;
		logic [47:0] home;
		logic [7:0] pum;
		logic start_pend;
		logic [47:0] raw;
		logic [47:0] pos;
		logic pos_valid;
		logic busy;
		logic done;
		logic skipped;
		logic badcode;
		logic req;
		logic [15:0] addr;
		logic xs;
		logic [5:0] width;
		logic is_signed;
		logic is_adc;
		logic [31:0] rdata;
		logic ack;
	} top_s;
	top_s q, d;
	logic [15:0] fetch_rd_addr;

	sensor_bus_if sb ();

	sensor_fetch u_fetch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sb(sb),
		.mem_rd_o(mem_rd_o),
		.mem_xspace_o(mem_xspace_o),
		.mem_addr_o(mem_addr_o),
		.mem_rdata_i(mem_rdata_i),
		.mem_valid_i(mem_valid_i)
	);

	assign sb.req = q.req;
	assign sb.xspace = q.xs;
	assign sb.addr = q.addr;
	assign fetch_rd_addr = q.addr;

	////////////////////////////////////////////////////////////
	// merge a byte-enabled write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// sign-extend from the configured width when signed, else zero-extend
	function automatic logic [47:0] extend(input logic [47:0] v, input logic [5:0] w, input logic sg);
		logic [47:0] r;
		r = '0;
		for (int i = 0; i < 48; i++) begin
			if (i < int'(w)) begin
				r[i] = v[i];
			end else begin
				r[i] = sg & v[int'(w) - 1];
			end
		end
		return r;
	endfunction : extend

	////////////////////////////////////////////////////////////
	// register bus, reader engine, position update
	always_comb begin
		logic [7:0] top;
		logic [5:0] wfield;
		logic [31:0] tmp;
		logic [47:0] val;
		top = '0;
		wfield = '0;
		tmp = '0;
		val = '0;
		d = q;
		d.ack = 1'b0;
		d.pos_valid = 1'b0;
		// avalon: request answered one cycle after it appears (waitrequest high for first cycle)
		if ((avs_read_i || avs_write_i) && !q.ack) begin
			d.ack = 1'b1;
			d.rdata = '0;
			if (avs_read_i) begin
				case (avs_address_i)
					REG_SOURCE_SELECT: d.rdata = {8'h00, q.sel};
					REG_HOME_OFFSET_LO: d.rdata = {8'h00, q.home[23:0]};
					REG_HOME_OFFSET_HI: d.rdata = {8'h00, q.home[47:24]};
					REG_POWER_UP_MODE: d.rdata = {24'h000000, q.pum};
					REG_STATUS: d.rdata = {28'h0000000, q.badcode, q.skipped, q.done, q.busy};
					REG_POSITION_LO: d.rdata = {8'h00, q.pos[23:0]};
					REG_POSITION_HI: d.rdata = {8'h00, q.pos[47:24]};
					REG_RAW_LO: d.rdata = {8'h00, q.raw[23:0]};
					REG_RAW_HI: d.rdata = {8'h00, q.raw[47:24]};
					default: d.rdata = '0;
				endcase
			end
		end
		// writes land at the edge where waitrequest is seen low, so a stalled master never writes twice
		if (avs_write_i && q.ack) begin
			begin
				case (avs_address_i)
					REG_SOURCE_SELECT: begin
						tmp = merge({8'h00, q.sel}, avs_writedata_i, avs_byteenable_i);
						d.sel = tmp[23:0];
					end
					REG_HOME_OFFSET_LO: begin
						tmp = merge({8'h00, q.home[23:0]}, avs_writedata_i, avs_byteenable_i);
						d.home[23:0] = tmp[23:0];
					end
					REG_HOME_OFFSET_HI: begin
						tmp = merge({8'h00, q.home[47:24]}, avs_writedata_i, avs_byteenable_i);
						d.home[47:24] = tmp[23:0];
					end
					REG_POWER_UP_MODE: begin
						if (avs_byteenable_i[0]) begin
							d.pum = avs_writedata_i[7:0];
						end
					end
					REG_CONTROL: begin
						// software-ordered read, ignores power-up suppression
						if (avs_byteenable_i[0] && avs_writedata_i[0]) begin
							d.start_pend = 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
		// read engine
		case (q.st)
			S_IDLE: begin
				if (q.start_pend) begin
					d.start_pend = 1'b0;
					d.st = S_DECIDE;
					d.busy = 1'b1;
					d.done = 1'b0;
					d.skipped = 1'b0;
					d.badcode = 1'b0;
				end
			end
			S_DECIDE: begin
				top = q.sel[23:16];
				wfield = q.sel[SEL_WIDTH_MSB:SEL_WIDTH_LSB];
				d.is_signed = q.sel[SEL_SIGNED_BIT];
				d.addr = q.sel[15:0];
				d.raw = '0;
				if (q.sel == 24'h000000) begin
					d.skipped = 1'b1;
					d.busy = 1'b0;
					d.st = S_IDLE;
				end else if ({1'b0, top[6:0]} == CODE_ADC) begin
					d.xs = 1'b0;
					d.is_adc = 1'b1;
					d.width = 6'd16;
					d.req = 1'b1;
					d.st = S_LOW;
				end else if ({1'b0, top[6:0]} == CODE_SERIAL_ENC) begin
					d.xs = 1'b0;
					d.is_adc = 1'b0;
					d.width = WIDTH_WORD;
					d.req = 1'b1;
					d.st = S_LOW;
				end else if (wfield >= WIDTH_MIN && wfield <= WIDTH_MAX) begin
					d.xs = q.sel[SEL_XSPACE_BIT];
					d.is_adc = 1'b0;
					d.width = wfield;
					d.req = 1'b1;
					d.st = S_LOW;
				end else begin
					// resolver and network sources are not served here
					d.badcode = 1'b1;
					d.busy = 1'b0;
					d.st = S_IDLE;
				end
			end
			S_LOW: begin
				d.req = 1'b0;
				if (sb.valid) begin
					if (q.is_adc) begin
						d.raw = {32'h00000000, sb.rdata[23:ADC_FIELD_LSB]};
						d.st = S_APPLY;
					end else begin
						d.raw = {24'h000000, sb.rdata};
						if (q.width > WIDTH_WORD) begin
							d.addr = fetch_rd_addr + 16'h0001;
							d.req = 1'b1;
							d.st = S_HIGH;
						end else begin
							d.st = S_APPLY;
						end
					end
				end
			end
			S_HIGH: begin
				d.req = 1'b0;
				if (sb.valid) begin
					d.raw = {sb.rdata, q.raw[23:0]};
					d.st = S_APPLY;
				end
			end
			S_APPLY: begin
				val = extend(q.raw, q.width, q.is_signed);
				d.raw = val;
				d.pos = val - q.home;
				d.pos_valid = 1'b1;
				d.done = 1'b1;
				d.busy = 1'b0;
				d.st = S_IDLE;
			end
			default: d.st = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////
	// state register; automatic read armed on reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= S_IDLE;
			q.sel <= SOURCE_SELECT_RST;
			q.home <= HOME_OFFSET_RST;
			q.pum <= POWER_UP_MODE_RST;
			q.start_pend <= 1'b1; // cleared below if suppressed
		end else begin
			q <= d;
			// suppression checked when the pending power-on read is launched
			if (q.st == S_IDLE && q.start_pend && q.pum[PUM_SUPPRESS_BIT] && !q.done && !q.skipped
				&& !q.badcode && q.pos == '0 && q.raw == '0) begin
				q.start_pend <= 1'b0;
				q.busy <= 1'b0;
				q.st <= S_IDLE;
				q.skipped <= 1'b1;
			end
		end
	end

	assign avs_readdata_o = q.rdata;
	assign avs_waitrequest_o = !q.ack;
	assign position_o = q.pos;
	assign position_valid_o = q.pos_valid;
endmodule : abs_position_reader

//--- core/abs_reader_pkg.sv
// package: register map, source-select field layout, reader states
// assumes: Avalon-MM word-addressed slave, 50 MHz clk_i, sync reset
package abs_reader_pkg;
	// register word offsets (byte address = 4 * index)
	localparam logic [3:0] REG_SOURCE_SELECT = 4'h0;
	localparam logic [3:0] REG_HOME_OFFSET_LO = 4'h1;
	localparam logic [3:0] REG_HOME_OFFSET_HI = 4'h2;
	localparam logic [3:0] REG_POWER_UP_MODE = 4'h3;
	localparam logic [3:0] REG_CONTROL = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_POSITION_LO = 4'h6;
	localparam logic [3:0] REG_POSITION_HI = 4'h7;
	localparam logic [3:0] REG_RAW_LO = 4'h8;
	localparam logic [3:0] REG_RAW_HI = 4'h9;
	// source-select field positions
	localparam int SEL_SIGNED_BIT = 23;
	localparam int SEL_XSPACE_BIT = 22;
	localparam int SEL_WIDTH_LSB = 16;
	localparam int SEL_WIDTH_MSB = 21;
	// top-byte codes and width limits
	localparam logic [7:0] CODE_ADC = 8'h31;
	localparam logic [7:0] CODE_SERIAL_ENC = 8'h32;
	localparam logic [5:0] WIDTH_MIN = 6'h08;
	localparam logic [5:0] WIDTH_MAX = 6'h30;
	localparam logic [5:0] WIDTH_WORD = 6'h18;
	localparam int ADC_FIELD_LSB = 8;
	// reset values
	localparam logic [23:0] SOURCE_SELECT_RST = 24'h000000;
	localparam logic [47:0] HOME_OFFSET_RST = 48'h000000000000;
	localparam logic [7:0] POWER_UP_MODE_RST = 8'h00;
	localparam int PUM_SUPPRESS_BIT = 2;
	// status bits
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SKIPPED = 2;
	localparam int ST_BADCODE = 3;
	// read engine states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DECIDE = 3'b001,
		S_LOW = 3'b010,
		S_HIGH = 3'b011,
		S_APPLY = 3'b100
	} rd_state_e;
endpackage : abs_reader_pkg

//--- core/sensor_bus_if.sv
// interface: internal sensor bus between reader engine and its fetch port
// assumes: one-word reads, answer marked by a one-cycle valid
interface sensor_bus_if;
	logic req;
	logic xspace;
	logic [15:0] addr;
	logic [23:0] rdata;
	logic valid;
	modport master (output req, output xspace, output addr, input rdata, input valid);
	modport port (input req, input xspace, input addr, output rdata, output valid);
endinterface : sensor_bus_if

//--- core/sensor_fetch.sv
// one-word fetch port onto the controller's internal X/Y bus
// assumes: external bus answers with mem_valid_i some cycles after mem_rd_o
module sensor_fetch
	import abs_reader_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	sensor_bus_if.port sb,
	// external memory bus
	output logic mem_rd_o,
	output logic mem_xspace_o,
	output logic [15:0] mem_addr_o,
	input wire logic [23:0] mem_rdata_i,
	input wire logic mem_valid_i
);
	typedef struct packed {
		logic rd;
		logic xs;
		logic [15:0] addr;
		logic [23:0] data;
		logic valid;
	} fetch_s;
	fetch_s q, d;

	////////////////////////////////////////////////////////////
	// hold the request until the bus answers
	always_comb begin
		d = q;
		d.valid = 1'b0;
		if (!q.rd && sb.req) begin
			d.rd = 1'b1;
			d.xs = sb.xspace;
			d.addr = sb.addr;
		end else if (q.rd && mem_valid_i) begin
			d.rd = 1'b0;
			d.data = mem_rdata_i;
			d.valid = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign mem_rd_o = q.rd;
	assign mem_xspace_o = q.xs;
	assign mem_addr_o = q.addr;
	assign sb.rdata = q.data;
	assign sb.valid = q.valid;
endmodule : sensor_fetch

//--- bench/sensor_mem_model.sv
// model: X/Y registers of a position board on the internal sensor bus
// assumes: fetch port holds mem_rd until it sees the one-cycle valid
module sensor_mem_model (
	// clock, reset, answer latency
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] lat_i,
	// sensor bus
	input wire logic mem_rd_i,
	input wire logic mem_xspace_i,
	input wire logic [15:0] mem_addr_i,
	output logic [23:0] mem_rdata_o,
	output logic mem_valid_o
);
	logic [3:0] cnt_q;
	logic busy_q;
	logic [15:0] ba_q;
	// one answer per address; idle data toggles so stale words never match
	always @(posedge clk_i) begin
		mem_valid_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (rst_i) begin
			mem_rdata_o <= 24'h0;
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
		end else if (!mem_rd_i) begin
			busy_q <= 1'b0;
		end else if (!busy_q || ba_q != mem_addr_i) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == lat_i) begin
				mem_valid_o <= 1'b1;
				mem_rdata_o <= {mem_xspace_i ? 8'hC3 : 8'hA5, mem_addr_i};
				busy_q <= 1'b1;
				ba_q <= mem_addr_i;
				cnt_q <= 4'h0;
			end
		end
	end
endmodule : sensor_mem_model

//--- bench/abs_reader_monitor.sv
// checker: bus timing and read-engine relations at the reader's ports
// assumes: bound into abs_position_reader, byteenable always full
module abs_reader_monitor
	import abs_reader_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	// sensor bus and result
	input wire logic mem_rd_o,
	input wire logic mem_xspace_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [23:0] mem_rdata_i,
	input wire logic mem_valid_i,
	input wire logic [47:0] position_o,
	input wire logic position_valid_o
);
	logic [23:0] sel_q;
	logic [23:0] dat_q;
	logic [47:0] home_q;
	logic [15:0] pa_q;
	logic have_q;
	logic wr;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign wr = avs_write_i && !avs_waitrequest_o;
	// shadow of setup writes and of the last fetched word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q <= 24'h0;
			home_q <= 48'h0;
			have_q <= 1'b0;
		end else begin
			if (wr && avs_address_i == REG_SOURCE_SELECT) sel_q <= avs_writedata_i[23:0];
			if (wr && avs_address_i == REG_HOME_OFFSET_LO) home_q[23:0] <= avs_writedata_i[23:0];
			if (wr && avs_address_i == REG_HOME_OFFSET_HI) home_q[47:24] <= avs_writedata_i[23:0];
			if (mem_rd_o && mem_valid_i) begin
				have_q <= 1'b1;
				pa_q <= mem_addr_o;
				dat_q <= mem_rdata_i;
			end else if (position_valid_o) have_q <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("no answer one cycle after request");
	chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than a cycle");
	chk_fetch_hold: assert property (mem_rd_o && !mem_valid_i |=> mem_rd_o && $stable(mem_addr_o))
		else $error("fetch dropped or moved before its answer");
	chk_first_addr: assert property ($rose(mem_rd_o) && !have_q |->
		mem_addr_o == sel_q[15:0] && mem_xspace_o == sel_q[22]) else $error("first fetch address or space wrong");
	chk_high_next: assert property ($rose(mem_rd_o) && have_q |-> mem_addr_o == pa_q + 16'h1)
		else $error("high word not at next address");
	chk_zero_skip: assert property (sel_q == 24'h0 |-> !mem_rd_o)
		else $error("fetch with zero source select");
	chk_pos_after: assert property (position_valid_o |-> have_q)
		else $error("position update without a fetch");
	chk_adc_upper: assert property (position_valid_o && sel_q[23:16] == CODE_ADC |->
		position_o == 48'(dat_q[23:8]) - home_q) else $error("converter position wrong");
	cover property (position_valid_o && sel_q[21:16] > WIDTH_WORD);
	cover property ($rose(mem_rd_o) && have_q);
	cover property (!avs_waitrequest_o && avs_read_i);
endmodule : abs_reader_monitor
bind abs_position_reader abs_reader_monitor abs_reader_monitor_inst(.*);

//--- bench/tb.sv
// testbench: register-driven absolute reads against a board model
// assumes: one reader, full byteenable, model latency varied per case
module tb
	import abs_reader_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o, rq;
	logic avs_waitrequest_o, mem_rd_o, mem_xspace_o, mem_valid_i, position_valid_o;
	logic [15:0] mem_addr_o;
	logic [23:0] mem_rdata_i;
	logic [47:0] position_o;
	logic [3:0] lat = 4'h0;
	logic [16:0] fq[$];
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [23:0] tab[14] = '{24'h18FFD0, 24'h18FFF1, 24'h58C038, 24'h58C03C,
		24'hD8C008, 24'h98FFD1, 24'h30FFD8, 24'hF0C010,
		24'h08FFD0, 24'hC8FFE8, 24'h31C006, 24'hB1C007,
		24'h32FFD4, 24'hB2FFFC};
	abs_position_reader abs_position_reader_inst(.*);
	sensor_mem_model sensor_mem_model_inst(.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mem_rd_i(mem_rd_o),
		.mem_xspace_i(mem_xspace_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i), .mem_valid_o(mem_valid_i));
	always #10 clk_i = ~clk_i;
	// cycle ceiling and log of answered fetches
	always @(posedge clk_i) begin
		cyc++;
		if (mem_rd_o && mem_valid_i) fq.push_back({mem_xspace_o, mem_addr_o});
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// held until waitrequest is sampled low; one idle edge after
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rq = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	function automatic logic [23:0] pat(input logic x, input logic [15:0] a);
		return {x ? 8'hC3 : 8'hA5, a};
	endfunction : pat
	function automatic logic [47:0] ev(input logic [23:0] s, output int nf);
		logic [47:0] r, m;
		int w;
		w = s[21:16];
		r = {pat(s[22], s[15:0] + 16'h1), pat(s[22], s[15:0])};
		if (s[22:16] == 7'h31) begin
			r = 48'(r[23:8]);
			w = 16;
		end
		if (s[22:16] == 7'h32) w = 24;
		nf = (w > 24) ? 2 : 1;
		m = (48'h1 << w) - 48'h1;
		r = r & m;
		if (s[23] && r[w-1]) r = r | ~m;
		return r;
	endfunction : ev
	// one software-started read; bit_i is the status bit expected
	task automatic run(input logic [23:0] s, input logic [47:0] h, input int bit_i);
		int n, nf;
		logic [47:0] e;
		e = ev(s, nf);
		fq = {};
		n = 0;
		bus(1'b1, REG_SOURCE_SELECT, {8'h0, s});
		bus(1'b1, REG_HOME_OFFSET_LO, {8'h0, h[23:0]});
		bus(1'b1, REG_HOME_OFFSET_HI, {8'h0, h[47:24]});
		bus(1'b1, REG_CONTROL, 32'h1);
		while (position_valid_o !== 1'b1 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
		if (bit_i == ST_DONE) begin
			chk(position_o, e - h);
			chk(48'(fq.size()), 48'(nf));
			chk(48'(fq[0]), {31'h0, s[22], s[15:0]});
			if (nf == 2) chk(48'(fq[1]), {31'h0, s[22], s[15:0] + 16'h1});
			bus(1'b0, REG_RAW_LO, 32'h0);
			chk(48'(rq[23:0]), {24'h0, e[23:0]});
		end else begin
			chk(48'(n), 48'h3C);
			chk(48'(fq.size()), 48'h0);
		end
		bus(1'b0, REG_STATUS, 32'h0);
		chk(48'(rq[bit_i]), 48'h1);
	endtask : run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	// reset, register checks, then every source kind
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(48'(rq[ST_SKIPPED]), 48'h1);
		bus(1'b0, REG_SOURCE_SELECT, 32'h0);
		chk(48'(rq), 48'h0);
		bus(1'b0, 4'hF, 32'h0);
		chk(48'(rq), 48'h0);
		run(24'h0, 48'h0, ST_SKIPPED);
		run(24'h710010, 48'h0, ST_BADCODE);
		for (int i = 0; i < 14; i++) begin
			lat <= 4'(i % 3 * 3);
			run(tab[i], {24'(i), 24'(i * 19)}, ST_DONE);
		end
		finish_test();
	end
endmodule : tb
